/* rtl/cpwm_cfg.svh */
// Purpose: Offsets, field positions and reset values of the complementary PWM block
// Assumes: 16-bit counter, word registers on a plain strobe port
// Notes: Summary of operation
// Summary of operation
// - Period register sets triangular count period
// - Toggle pin inverts every half period
// - Compare one drives output 1 pin pair
// - Compare two drives output 2 pin pair
// - Compare three drives output 3 pin pair
// - General register c0 has no function
// - Buffer one holds next output 1 point
// - Buffer two holds next output 2 point
// - Buffer three holds next output 3 point
// - Dead-time counter preload, up/down, overflow flag
// - Toggle pin starts at initial-level bit
// - Count-start flags start and stop counters
`ifndef CPWM_CFG_SVH
`define CPWM_CFG_SVH
`define ADDR_PERIOD 4'h0
`define ADDR_PWM1 4'h1
`define ADDR_PWM2 4'h2
`define ADDR_PWM3 4'h3
`define ADDR_GEN_C0 4'h4
`define ADDR_BUF1 4'h5
`define ADDR_BUF2 4'h6
`define ADDR_BUF3 4'h7
`define ADDR_DEAD 4'h8
`define ADDR_START 4'h9
`define ADDR_CTRL 4'hA
`define ADDR_STATUS 4'hB
`define ADDR_PORT1 4'hC
`define BIT_START0 0
`define BIT_START1 1
`define BIT_BUF1_EN 0
`define BIT_BUF2_EN 1
`define BIT_BUF3_EN 2
`define BIT_TOGGLE_INIT 3
`define BIT_OVF 0
`define RST_PERIOD 16'hFFFF
`define RST_DEAD 16'h0001
`define RST_ZERO 16'h0000
`endif

/* rtl/cpwm_core.sv */
// Purpose: Three-phase complementary PWM with dead time and buffered change points
// Assumes: Count source is clk_sys; software keeps documented value ranges
// Notes: Read data valid the cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
`include "cpwm_cfg.svh"
module cpwm_core (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire cpwm_pkg::bus_req_t bus_req,
	output logic [15:0] rdata,
	output logic half_period_toggle_pin,
	output cpwm_pkg::pin_pair_t pwm1_pin,
	output cpwm_pkg::pin_pair_t pwm2_pin,
	output cpwm_pkg::pin_pair_t pwm3_pin,
	output logic [7:0] port_one_latch
);
	logic [15:0] period_compare;
	logic [15:0] unused_general_c0;
	logic [15:0] dead_time;
	logic [15:0] dead_time_counter;
	logic [15:0] cmp [3];
	logic [15:0] buf_q [3];
	logic [2:0] buf_en;
	logic toggle_initial_level;
	logic chan0_count_start;
	logic chan1_count_start;
	logic ovf;
	logic running;
	logic [15:0] tri_cnt;
	cpwm_pkg::dir_t dir;
	logic at_top;
	logic at_bottom;
	logic [2:0] level;
	logic [15:0] dt_cnt [3];
	logic [2:0] nrm;
	logic [2:0] cnt;
	logic wr;

	assign wr = bus_req.wr;
	// Counting only with both channels started
	assign running = chan0_count_start & chan1_count_start;
	assign at_top = (tri_cnt == period_compare);
	assign at_bottom = (tri_cnt == `RST_ZERO);

	// Register writes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			period_compare <= `RST_PERIOD;
			unused_general_c0 <= `RST_ZERO;
			dead_time <= `RST_DEAD;
			buf_en <= 3'h0;
			toggle_initial_level <= 1'b0;
			chan0_count_start <= 1'b0;
			chan1_count_start <= 1'b0;
			port_one_latch <= 8'h00;
		end else if (wr) begin
			case (bus_req.addr)
				`ADDR_PERIOD: period_compare <= bus_req.wdata;
				`ADDR_GEN_C0: unused_general_c0 <= bus_req.wdata;
				`ADDR_DEAD: dead_time <= bus_req.wdata;
				`ADDR_CTRL: begin
					buf_en <= bus_req.wdata[2:0];
					toggle_initial_level <= bus_req.wdata[`BIT_TOGGLE_INIT];
				end
				`ADDR_START: begin
					chan0_count_start <= bus_req.wdata[`BIT_START0];
					chan1_count_start <= bus_req.wdata[`BIT_START1];
				end
				`ADDR_PORT1: port_one_latch <= bus_req.wdata[7:0];
				default: ;
			endcase
		end
	end

	// Triangular counter, preloaded with the dead time while stopped
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tri_cnt <= `RST_ZERO;
			dir <= cpwm_pkg::DIR_UP;
		end else if (!running) begin
			tri_cnt <= dead_time;
			dir <= cpwm_pkg::DIR_UP;
		end else begin
			case (dir)
				cpwm_pkg::DIR_UP: begin
					if (at_top) begin
						dir <= cpwm_pkg::DIR_DOWN;
						tri_cnt <= tri_cnt - 16'h0001;
					end else begin
						tri_cnt <= tri_cnt + 16'h0001;
					end
				end
				cpwm_pkg::DIR_DOWN: begin
					if (at_bottom) begin
						dir <= cpwm_pkg::DIR_UP;
						tri_cnt <= tri_cnt + 16'h0001;
					end else begin
						tri_cnt <= tri_cnt - 16'h0001;
					end
				end
				default: dir <= cpwm_pkg::DIR_UP;
			endcase
		end
	end
	assign dead_time_counter = tri_cnt;

	// Overflow flag: counter wrapping past all-ones; cleared by writing status with bit 0 low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ovf <= 1'b0;
		end else if (running && dir == cpwm_pkg::DIR_UP && tri_cnt == 16'hFFFF && !at_top) begin
			ovf <= 1'b1;
		end else if (wr && bus_req.addr == `ADDR_STATUS && !bus_req.wdata[`BIT_OVF]) begin
			ovf <= 1'b0;
		end
	end

	// Half-period toggle at each turn of the triangle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			half_period_toggle_pin <= 1'b0;
		end else if (!running) begin
			half_period_toggle_pin <= toggle_initial_level;
		end else if ((dir == cpwm_pkg::DIR_UP && at_top) ||
				(dir == cpwm_pkg::DIR_DOWN && at_bottom)) begin
			half_period_toggle_pin <= ~half_period_toggle_pin;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_phase
			// Compare and buffer register per output
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					cmp[g] <= `RST_ZERO;
					buf_q[g] <= `RST_ZERO;
				end else begin
					if (wr && bus_req.addr == 4'(`ADDR_PWM1 + g)) begin
						cmp[g] <= bus_req.wdata;
					end else if (running && buf_en[g] && dir == cpwm_pkg::DIR_DOWN && at_bottom) begin
						cmp[g] <= buf_q[g];
					end
					if (wr && bus_req.addr == 4'(`ADDR_BUF1 + g)) begin
						buf_q[g] <= bus_req.wdata;
					end
				end
			end
			assign level[g] = running && (tri_cnt >= cmp[g]);
			// Dead-time delayed rising edges on each side
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					dt_cnt[g] <= `RST_ZERO;
					nrm[g] <= 1'b0;
					cnt[g] <= 1'b0;
				end else if (!running) begin
					// Both pins idle while stopped; dead time again on restart
					nrm[g] <= 1'b0;
					cnt[g] <= 1'b0;
					dt_cnt[g] <= dead_time;
				end else if (level[g] != nrm[g] && level[g] == cnt[g]) begin
					// Level changed: drop active side at once, start dead time
					nrm[g] <= 1'b0;
					cnt[g] <= 1'b0;
					dt_cnt[g] <= dead_time;
				end else if (!nrm[g] && !cnt[g]) begin
					if (dt_cnt[g] > 16'h0001) begin
						dt_cnt[g] <= dt_cnt[g] - 16'h0001;
					end else if (running) begin
						nrm[g] <= level[g];
						cnt[g] <= ~level[g];
					end
				end
			end
		end
	endgenerate

	assign pwm1_pin = '{normal: nrm[0], counter: cnt[0]};
	assign pwm2_pin = '{normal: nrm[1], counter: cnt[1]};
	assign pwm3_pin = '{normal: nrm[2], counter: cnt[2]};

	// Read data the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= `RST_ZERO;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				`ADDR_PERIOD: rdata <= period_compare;
				`ADDR_PWM1: rdata <= cmp[0];
				`ADDR_PWM2: rdata <= cmp[1];
				`ADDR_PWM3: rdata <= cmp[2];
				`ADDR_GEN_C0: rdata <= unused_general_c0;
				`ADDR_BUF1: rdata <= buf_q[0];
				`ADDR_BUF2: rdata <= buf_q[1];
				`ADDR_BUF3: rdata <= buf_q[2];
				`ADDR_DEAD: rdata <= dead_time_counter;
				`ADDR_START: rdata <= {14'h0000, chan1_count_start, chan0_count_start};
				`ADDR_CTRL: rdata <= {12'h000, toggle_initial_level, buf_en};
				`ADDR_STATUS: rdata <= {15'h0000, ovf};
				`ADDR_PORT1: rdata <= {8'h00, port_one_latch};
				default: rdata <= `RST_ZERO;
			endcase
		end else begin
			rdata <= `RST_ZERO;
		end
	end

	// Counter and toggle checks
	a_toggle_half: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(running && $past(running) && dir == cpwm_pkg::DIR_UP && at_top) |=>
		half_period_toggle_pin != $past(half_period_toggle_pin))
		else $error("toggle pin did not invert at top");
	a_toggle_bottom: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(running && dir == cpwm_pkg::DIR_DOWN && at_bottom) |=>
		half_period_toggle_pin != $past(half_period_toggle_pin))
		else $error("toggle pin did not invert at bottom");
	a_toggle_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(running && !(dir == cpwm_pkg::DIR_UP && at_top) &&
		!(dir == cpwm_pkg::DIR_DOWN && at_bottom))
		|=> $stable(half_period_toggle_pin))
		else $error("toggle pin moved between turns");
	a_toggle_init: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!running |=> half_period_toggle_pin == $past(toggle_initial_level))
		else $error("toggle pin not at initial level");
	a_period_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(running && $past(running) && $past(at_top) && $past(dir) == cpwm_pkg::DIR_UP)
		|-> dir == cpwm_pkg::DIR_DOWN)
		else $error("counter did not turn at period");
	a_bottom_turn: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(running && $past(running) && $past(at_bottom) && $past(dir) == cpwm_pkg::DIR_DOWN)
		|-> dir == cpwm_pkg::DIR_UP)
		else $error("counter did not turn at bottom");
	a_up_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(running && dir == cpwm_pkg::DIR_UP && !at_top)
		|=> tri_cnt == 16'($past(tri_cnt) + 16'h0001))
		else $error("counter did not count up");
	a_down_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(running && dir == cpwm_pkg::DIR_DOWN && !at_bottom)
		|=> tri_cnt == 16'($past(tri_cnt) - 16'h0001))
		else $error("counter did not count down");
	a_stop_preload: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && !running) |=> tri_cnt == $past(dead_time))
		else $error("counter not preloaded");

	// Compare and buffer checks
	a_cmp1_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr && bus_req.addr == `ADDR_PWM1) |=> cmp[0] == $past(bus_req.wdata))
		else $error("compare write lost");
	a_cmp2_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr && bus_req.addr == `ADDR_PWM2) |=> cmp[1] == $past(bus_req.wdata))
		else $error("compare write lost");
	a_cmp_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr && bus_req.addr == `ADDR_PWM3) |=> cmp[2] == $past(bus_req.wdata))
		else $error("compare write lost");
	a_buf1_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr && bus_req.addr == `ADDR_BUF1) |=> buf_q[0] == $past(bus_req.wdata))
		else $error("buffer write lost");
	a_buf2_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr && bus_req.addr == `ADDR_BUF2) |=> buf_q[1] == $past(bus_req.wdata))
		else $error("buffer write lost");
	a_buf3_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr && bus_req.addr == `ADDR_BUF3) |=> buf_q[2] == $past(bus_req.wdata))
		else $error("buffer write lost");
	a_buf_xfer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(running && buf_en[0] && dir == cpwm_pkg::DIR_DOWN && at_bottom && !wr)
		|=> cmp[0] == $past(buf_q[0]))
		else $error("buffer not transferred");
	a_buf_xfer2: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(running && buf_en[1] && dir == cpwm_pkg::DIR_DOWN && at_bottom && !wr)
		|=> cmp[1] == $past(buf_q[1]))
		else $error("buffer not transferred");
	a_buf_xfer3: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(running && buf_en[2] && dir == cpwm_pkg::DIR_DOWN && at_bottom && !wr)
		|=> cmp[2] == $past(buf_q[2]))
		else $error("buffer not transferred");
	a_buf_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && !buf_en[0] && !(wr && bus_req.addr == `ADDR_PWM1))
		|=> $stable(cmp[0]))
		else $error("compare moved with buffer off");

	// Pin and control checks
	a_pair_excl: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(nrm[0] && cnt[0]) && !(nrm[1] && cnt[1]) && !(nrm[2] && cnt[2]))
		else $error("both phases active");
	a_dead_nrm: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(nrm[0]) |-> !$past(cnt[0]))
		else $error("normal pin rose without dead time");
	a_dead_cnt: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(cnt[0]) |-> !$past(nrm[0]))
		else $error("counter pin rose without dead time");
	a_stop_pins: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!running [*2] |=> !nrm[1] && !cnt[1])
		else $error("pins active while stopped");
	a_start_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr && bus_req.addr == `ADDR_START && bus_req.wdata[1:0] == 2'b11)
		|=> running)
		else $error("counting did not start");
	a_start_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr && bus_req.addr == `ADDR_START && bus_req.wdata[1:0] != 2'b11)
		|=> !running)
		else $error("counting did not stop");
	a_rd_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(bus_req.rd && bus_req.addr == `ADDR_PERIOD) |=> rdata == $past(period_compare))
		else $error("period read wrong");
endmodule
`default_nettype wire

/* rtl/cpwm_pkg.sv */
// Purpose: Types shared by the complementary PWM block
// Assumes: Constants live in cpwm_cfg.svh
// Notes: Register bus request travels as one struct
package cpwm_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;
	typedef struct packed {
		logic normal;
		logic counter;
	} pin_pair_t;
	typedef enum logic [1:0] {
		DIR_UP = 2'b01,
		DIR_DOWN = 2'b10
	} dir_t;
endpackage

/* tb/testbench.sv */
// Purpose: Self-checking bench for the complementary PWM block
// Assumes: Registers reached by index; pins sampled one step after each edge
// Notes: Short period and dead time keep the run brief
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int P = 40;
	localparam int D = 2;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	cpwm_pkg::bus_req_t bus_req = '0;
	logic [15:0] rdata;
	logic half_period_toggle_pin;
	cpwm_pkg::pin_pair_t pwm1_pin, pwm2_pin, pwm3_pin;
	logic [7:0] port_one_latch;
	int fails = 0;
	int cmp_count = 0;
	int hi[3];
	int lo[3];
	int gap;
	bit ovl;
	logic [15:0] d;
	logic [15:0] nv[3];
	logic [3:0] idx[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'hC};
	always #2.5 clk_sys = ~clk_sys;
	cpwm_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
		.half_period_toggle_pin(half_period_toggle_pin), .pwm1_pin(pwm1_pin),
		.pwm2_pin(pwm2_pin), .pwm3_pin(pwm3_pin), .port_one_latch(port_one_latch));
	function automatic logic [15:0] rst_val(logic [3:0] a);
		return (a == 4'h0) ? 16'hFFFF : (a == 4'h8) ? 16'h0001 : 16'h0000;
	endfunction
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] w);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a, output logic [15:0] r);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1 r = rdata;
	endtask
	task automatic run(int n);
		int last;
		logic tp;
		last = 0;
		gap = 0;
		ovl = 0;
		hi = '{0, 0, 0};
		lo = '{0, 0, 0};
		tp = half_period_toggle_pin;
		for (int i = 1; i <= n; i++) begin
			@(posedge clk_sys);
			#1;
			hi[0] += pwm1_pin.normal;
			hi[1] += pwm2_pin.normal;
			hi[2] += pwm3_pin.normal;
			lo[0] += pwm1_pin.counter;
			lo[1] += pwm2_pin.counter;
			lo[2] += pwm3_pin.counter;
			if ((pwm1_pin === 2'b11) || (pwm2_pin === 2'b11) || (pwm3_pin === 2'b11)) ovl = 1;
			if (half_period_toggle_pin !== tp) begin
				if (last != 0) gap = i - last;
				last = i;
			end
			tp = half_period_toggle_pin;
		end
	endtask
	function automatic bit duty_ok(int h, int c);
		return (h >= 4 * (P - c) - 4 * D - 4) && (h <= 4 * (P - c) + 4);
	endfunction
	function automatic bit cnt_ok(int h, int c);
		return (h >= 4 * c - 4 * D - 4) && (h <= 4 * c + 4);
	endfunction
	task automatic end_of_test();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#60000;
		fails++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h3f4e007a));
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		foreach (idx[i]) begin
			nv[0] = 16'($urandom());
			wr(idx[i], nv[0]);
			rd(idx[i], d);
			check("readback", d, (idx[i] == 4'hC) ? {8'h00, nv[0][7:0]} : nv[0]);
		end
		$display("test readback done");
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int a = 0; a < 4'hC; a++) begin
			if (a != 4) begin
				rd(4'(a), d);
				check("reset value", d, rst_val(4'(a)));
			end
		end
		rd(4'hD, d);
		check("unmapped", d, 16'h0000);
		$display("test reset done");
		wr(4'h8, 16'(D));
		wr(4'h0, 16'(P));
		for (int k = 0; k < 3; k++) begin
			wr(4'(1 + k), 16'(10 * (k + 1)));
			wr(4'(5 + k), 16'(10 * (k + 1)));
		end
		wr(4'h4, 16'h0005);
		wr(4'hA, 16'h000F);
		wr(4'h9, 16'h0003);
		repeat (2) @(posedge clk_sys);
		#1 check("toggle init", 16'(half_period_toggle_pin), 16'h0001);
		run(4 * P);
		run(4 * P);
		check("half period", 16'(gap), 16'(P));
		check("overlap", 16'(ovl), 16'h0000);
		check("duty 1", 16'(duty_ok(hi[0], 10)), 16'h0001);
		check("duty 2", 16'(duty_ok(hi[1], 20)), 16'h0001);
		check("duty 3", 16'(duty_ok(hi[2], 30)), 16'h0001);
		check("counter 1", 16'(cnt_ok(lo[0], 10)), 16'h0001);
		check("counter 2", 16'(cnt_ok(lo[1], 20)), 16'h0001);
		check("counter 3", 16'(cnt_ok(lo[2], 30)), 16'h0001);
		$display("test waveform done");
		for (int k = 0; k < 3; k++) begin
			nv[k] = 16'(D + ($urandom() % (P - 2 * D + 1)));
			wr(4'(5 + k), nv[k]);
		end
		run(3 * P);
		rd(4'h1, d);
		check("pwm1 update", d, nv[0]);
		rd(4'h2, d);
		check("pwm2 update", d, nv[1]);
		rd(4'h3, d);
		check("pwm3 update", d, nv[2]);
		wr(4'hA, 16'h0000);
		wr(4'h5, 16'(P - D));
		run(3 * P);
		rd(4'h1, d);
		check("buffer off", d, nv[0]);
		$display("test buffer done");
		wr(4'h9, 16'h0001);
		rd(4'h8, d);
		check("stopped count", d, 16'(D));
		nv[0] = 16'($urandom() % 256);
		wr(4'hC, nv[0]);
		@(posedge clk_sys);
		#1 check("port latch", 16'(port_one_latch), nv[0]);
		$display("test stop and port done");
		end_of_test();
	end
endmodule
`default_nettype wire
